// >>> verilog/usp_pkg.sv
package usp_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SE0_RESET_NS = 2500;
    localparam int SE0_RESET_CYCLES = (SE0_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUSPEND_IDLE_US = 3000;
    localparam int SUSPEND_CYCLES_DEF = (SUSPEND_IDLE_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int WAKE_ACCESS_US = 2500;
    localparam int WAKE_CYCLES_DEF = (WAKE_ACCESS_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    localparam int DMA_CHANNELS = 2;
    localparam logic [6:0] WAKE_ACCESS_ADDR = 7'h7E;
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_J = 2'h2;
    localparam logic [1:0] HSK_UNDECIDED = 2'h0;
    localparam logic [1:0] HSK_IN_PROGRESS = 2'h1;
    localparam logic [1:0] HSK_FULL_SPEED = 2'h2;
    localparam logic [1:0] HSK_HIGH_SPEED = 2'h3;
    localparam logic [1:0] MODE_OTHER = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] MODE_CLOCK_STOP = 2'h3;

    typedef struct packed {
        logic [1:0] crystal_freq_sel;
        logic osc_buffer_enable;
        logic ref_clock_enable;
        logic pll_enable;
        logic internal_clock_enable;
        logic auto_clock_supply_mode;
        logic high_speed_enable;
        logic dplus_pullup_enable;
        logic sleep_control;
        logic controller_enable;
    } usp_sys_cfg_type;

    typedef struct packed {
        logic drive_strength_sel;
        logic byte_order_sel;
    } usp_pin_cfg_type;

    typedef struct packed {
        logic dma_req_polarity;
        logic dma_ack_polarity;
        logic dma_end_polarity;
        logic output_bus_mode;
    } usp_dma_cfg_type;

    typedef struct packed {
        logic vbus_change_irq_enable;
        logic resume_irq_enable;
        logic irq_output_sense;
        logic wake_on_access_ctrl;
    } usp_irq_cfg_type;

    typedef struct packed {
        logic vbus_change_flag;
        logic resume_flag;
    } usp_irq_flag_type;

    typedef struct packed {
        logic [1:0] handshake_result;
        logic hs_active;
        logic suspended;
        logic bus_reset;
        logic line_change;
    } usp_line_status_type;

    typedef struct packed {
        logic pullup_on;
        logic hs_term_on;
        logic fs_drv_on;
    } usp_pad_ctrl_type;

    typedef enum logic [2:0] {
        PS_RUN = 3'b001,
        PS_SLEEP = 3'b010,
        PS_WAKE = 3'b100
    } usp_pwr_state_type;

    localparam usp_sys_cfg_type SYS_CFG_RESET = '0;
    localparam usp_pin_cfg_type PIN_CFG_RESET = '0;
    localparam usp_dma_cfg_type DMA_CFG_RESET = '0;
    localparam usp_irq_cfg_type IRQ_CFG_RESET = '0;
endpackage

// >>> verilog/usp_sync.sv
`timescale 1ns/10ps
module usp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_sync_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    // take a change only once stages two and three agree
    always_comb
    begin
        out_next = ((stage2_reg ~^ stage3_reg) & stage2_reg)
            | ((stage2_reg ^ stage3_reg) & out_reg);
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            out_reg <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule // usp_sync

// >>> verilog/usp_line_mon.sv
`timescale 1ns/10ps
module usp_line_mon #(
    parameter int SUSPEND_CYCLES = usp_pkg::SUSPEND_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst_sync_b,
    input wire logic enable,
    input wire logic high_speed_enable,
    input wire logic host_chirp,
    input wire logic [1:0] line,
    output usp_pkg::usp_line_status_type status
);
    import usp_pkg::*;

    logic [CNT_W-1:0] se0_cnt_reg, se0_cnt_next;
    logic [CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
    logic [1:0] line_prev_reg;
    usp_line_status_type status_reg, status_next;

    always_comb
    begin
        status_next = status_reg;
        status_next.bus_reset = 1'b0;
        status_next.line_change = (line != line_prev_reg);
        se0_cnt_next = '0;
        idle_cnt_next = '0;
        if (line == LINE_SE0 && se0_cnt_reg != CNT_W'(SE0_RESET_CYCLES))
            se0_cnt_next = se0_cnt_reg + 1'b1;
        else if (line == LINE_SE0)
            se0_cnt_next = se0_cnt_reg;
        if (line == LINE_J && idle_cnt_reg != CNT_W'(SUSPEND_CYCLES))
            idle_cnt_next = idle_cnt_reg + 1'b1;
        else if (line == LINE_J)
            idle_cnt_next = idle_cnt_reg;
        if (idle_cnt_next == CNT_W'(SUSPEND_CYCLES))
            status_next.suspended = 1'b1;
        else if (line != LINE_J)
            status_next.suspended = 1'b0;
        if (se0_cnt_next == CNT_W'(SE0_RESET_CYCLES) && se0_cnt_reg != se0_cnt_next)
        begin
            status_next.bus_reset = 1'b1;
            status_next.hs_active = 1'b0;
            status_next.handshake_result = high_speed_enable ? HSK_IN_PROGRESS
                : HSK_FULL_SPEED;
        end
        else if (status_reg.handshake_result == HSK_IN_PROGRESS)
        begin
            if (host_chirp)
            begin
                status_next.handshake_result = HSK_HIGH_SPEED;
                status_next.hs_active = 1'b1;
            end
            else if (line != LINE_SE0)
                status_next.handshake_result = HSK_FULL_SPEED;
        end
        if (!enable)
        begin
            status_next = '0;
            se0_cnt_next = '0;
            idle_cnt_next = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            se0_cnt_reg <= '0;
            idle_cnt_reg <= '0;
            line_prev_reg <= LINE_SE0;
            status_reg <= '0;
        end
        else
        begin
            se0_cnt_reg <= se0_cnt_next;
            idle_cnt_reg <= idle_cnt_next;
            line_prev_reg <= line;
            status_reg <= status_next;
        end
    end

    assign status = status_reg;
endmodule // usp_line_mon

// >>> verilog/usp_power_ctrl.sv
`timescale 1ns/10ps
module usp_power_ctrl #(
    parameter int SUSPEND_CYCLES = usp_pkg::SUSPEND_CYCLES_DEF,
    parameter int WAKE_CYCLES = usp_pkg::WAKE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sys_wr,
    input wire usp_pkg::usp_sys_cfg_type sys_wdata,
    input wire logic pin_wr,
    input wire usp_pkg::usp_pin_cfg_type pin_wdata,
    input wire logic [usp_pkg::DMA_CHANNELS-1:0] dma_wr,
    input wire usp_pkg::usp_dma_cfg_type dma_wdata,
    input wire logic irq_wr,
    input wire usp_pkg::usp_irq_cfg_type irq_wdata,
    input wire usp_pkg::usp_irq_flag_type irq_clr,
    input wire logic cpu_wr,
    input wire logic [6:0] cpu_addr,
    input wire logic dplus_in,
    input wire logic dminus_in,
    input wire logic vbus_in,
    input wire logic host_chirp,
    output usp_pkg::usp_sys_cfg_type system_config_reg,
    output usp_pkg::usp_pin_cfg_type pin_config_reg,
    output usp_pkg::usp_dma_cfg_type [usp_pkg::DMA_CHANNELS-1:0] dma_channel_config_reg,
    output usp_pkg::usp_irq_cfg_type irq_config_reg,
    output usp_pkg::usp_irq_flag_type irq_status_reg_0,
    output logic [1:0] handshake_result,
    output logic hs_mode,
    output logic bus_reset,
    output usp_pkg::usp_pad_ctrl_type pad_ctrl,
    output logic irq_pin_out,
    output logic [1:0] pwr_mode,
    output logic access_ready
);
    import usp_pkg::*;

    logic rst_meta_reg;
    logic rst_sync_b;
    logic [1:0] line_sync;
    logic vbus_sync;
    logic vbus_prev_reg;
    logic vbus_change;
    logic resume_event;
    logic wake_access;
    logic wake_event;
    logic accept;
    usp_line_status_type line_status;

    usp_pwr_state_type state_reg, state_next;
    logic [CNT_W-1:0] wake_cnt_reg, wake_cnt_next;
    usp_sys_cfg_type sys_reg, sys_next;
    usp_pin_cfg_type pin_reg, pin_next;
    usp_dma_cfg_type [DMA_CHANNELS-1:0] dma_reg, dma_next;
    usp_irq_cfg_type irq_cfg_reg, irq_cfg_next;
    usp_irq_flag_type flag_reg, flag_next;
    usp_pad_ctrl_type pad_reg, pad_next;
    logic irq_out_reg, irq_out_next;
    logic [1:0] mode_reg, mode_next;

    function automatic logic [1:0] mode_of(input usp_sys_cfg_type c);
        logic clocks_on;
        logic clocks_off;
        clocks_on = c.osc_buffer_enable & c.ref_clock_enable & c.internal_clock_enable;
        clocks_off = ~(c.osc_buffer_enable | c.ref_clock_enable | c.pll_enable
            | c.internal_clock_enable);
        mode_of = MODE_OTHER;
        if (clocks_on && !c.sleep_control && c.controller_enable)
            mode_of = MODE_NORMAL;
        else if (clocks_off && c.sleep_control && c.controller_enable)
            mode_of = MODE_SLEEP;
        else if (clocks_off && !c.sleep_control && c.auto_clock_supply_mode
            && c.controller_enable)
            mode_of = MODE_CLOCK_STOP;
    endfunction

    // reset pin released through two flops
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_b <= rst_meta_reg;
        end
    end

    usp_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .async_in({dplus_in, dminus_in, vbus_in}),
        .sync_out({line_sync, vbus_sync})
    );

    usp_line_mon #(
        .SUSPEND_CYCLES(SUSPEND_CYCLES)
    ) u_line_mon (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .enable(sys_reg.controller_enable),
        .high_speed_enable(sys_reg.high_speed_enable),
        .host_chirp(host_chirp),
        .line(line_sync),
        .status(line_status)
    );

    assign accept = (state_reg == PS_RUN);
    assign vbus_change = (vbus_sync != vbus_prev_reg);
    assign resume_event = line_status.line_change
        & (line_status.suspended | (state_reg == PS_SLEEP));
    assign wake_access = cpu_wr && cpu_addr == WAKE_ACCESS_ADDR
        && !irq_cfg_reg.wake_on_access_ctrl;
    assign wake_event = wake_access
        | (vbus_change & irq_cfg_reg.vbus_change_irq_enable)
        | (resume_event & irq_cfg_reg.resume_irq_enable);

    // configuration and power state
    always_comb
    begin
        state_next = state_reg;
        wake_cnt_next = '0;
        sys_next = sys_reg;
        pin_next = pin_reg;
        dma_next = dma_reg;
        irq_cfg_next = irq_cfg_reg;
        case (state_reg)
            PS_RUN:
            begin
                if (sys_wr)
                begin
                    sys_next = sys_wdata;
                    // device keeps oscillator buffer until sleep
                    sys_next.osc_buffer_enable = sys_wdata.osc_buffer_enable
                        | sys_reg.osc_buffer_enable;
                end
                if (pin_wr)
                    pin_next = pin_wdata;
                if (irq_wr)
                    irq_cfg_next = irq_wdata;
                for (int ch = 0; ch < DMA_CHANNELS; ch++)
                begin
                    if (dma_wr[ch])
                        dma_next[ch] = dma_wdata;
                end
                if (sys_wr && sys_wdata.sleep_control)
                begin
                    state_next = PS_SLEEP;
                    sys_next.sleep_control = 1'b1;
                    sys_next.ref_clock_enable = 1'b0;
                    sys_next.pll_enable = 1'b0;
                    sys_next.internal_clock_enable = 1'b0;
                    sys_next.osc_buffer_enable = 1'b0;
                    pin_next = PIN_CFG_RESET;
                    irq_cfg_next = IRQ_CFG_RESET;
                    pin_next.drive_strength_sel = pin_reg.drive_strength_sel;
                    irq_cfg_next.vbus_change_irq_enable = irq_cfg_reg.vbus_change_irq_enable;
                    irq_cfg_next.resume_irq_enable = irq_cfg_reg.resume_irq_enable;
                    for (int ch = 0; ch < DMA_CHANNELS; ch++)
                    begin
                        dma_next[ch] = DMA_CFG_RESET;
                        dma_next[ch].dma_req_polarity = dma_reg[ch].dma_req_polarity;
                    end
                end
            end
            PS_SLEEP:
            begin
                if (wake_event)
                begin
                    sys_next.sleep_control = 1'b0;
                    sys_next.osc_buffer_enable = 1'b1;
                    state_next = sys_reg.auto_clock_supply_mode ? PS_WAKE : PS_RUN;
                end
            end
            PS_WAKE:
            begin
                wake_cnt_next = wake_cnt_reg + 1'b1;
                if (wake_cnt_reg == CNT_W'(WAKE_CYCLES - 1))
                begin
                    sys_next.ref_clock_enable = 1'b1;
                    sys_next.pll_enable = 1'b1;
                    sys_next.internal_clock_enable = 1'b1;
                    state_next = PS_RUN;
                end
            end
            default:
            begin
                state_next = PS_RUN;
            end
        endcase
        if (!accept && state_reg != PS_SLEEP && state_reg != PS_WAKE)
            state_next = PS_RUN;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state_reg <= PS_RUN;
            wake_cnt_reg <= '0;
            sys_reg <= SYS_CFG_RESET;
            pin_reg <= PIN_CFG_RESET;
            dma_reg <= {DMA_CHANNELS{DMA_CFG_RESET}};
            irq_cfg_reg <= IRQ_CFG_RESET;
        end
        else
        begin
            state_reg <= state_next;
            wake_cnt_reg <= wake_cnt_next;
            sys_reg <= sys_next;
            pin_reg <= pin_next;
            dma_reg <= dma_next;
            irq_cfg_reg <= irq_cfg_next;
        end
    end

    // flags, interrupt pin, pads and mode
    always_comb
    begin
        flag_next = flag_reg & ~irq_clr;
        if (vbus_change)
            flag_next.vbus_change_flag = 1'b1;
        if (resume_event)
            flag_next.resume_flag = 1'b1;
        irq_out_next = (flag_next.vbus_change_flag & irq_cfg_next.vbus_change_irq_enable)
            | (flag_next.resume_flag & irq_cfg_next.resume_irq_enable);
        if (!irq_cfg_next.irq_output_sense)
            irq_out_next = ~irq_out_next;
        pad_next = '0;
        if (sys_next.dplus_pullup_enable && sys_next.controller_enable)
        begin
            pad_next.hs_term_on = line_status.hs_active & ~line_status.suspended
                & sys_next.high_speed_enable;
            pad_next.pullup_on = ~pad_next.hs_term_on;
            pad_next.fs_drv_on = ~pad_next.hs_term_on;
        end
        mode_next = mode_of(sys_next);
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            vbus_prev_reg <= 1'b0;
            flag_reg <= '0;
            irq_out_reg <= 1'b1;
            pad_reg <= '0;
            mode_reg <= MODE_OTHER;
        end
        else
        begin
            vbus_prev_reg <= vbus_sync;
            flag_reg <= flag_next;
            irq_out_reg <= irq_out_next;
            pad_reg <= pad_next;
            mode_reg <= mode_next;
        end
    end

    assign system_config_reg = sys_reg;
    assign pin_config_reg = pin_reg;
    assign dma_channel_config_reg = dma_reg;
    assign irq_config_reg = irq_cfg_reg;
    assign irq_status_reg_0 = flag_reg;
    assign handshake_result = line_status.handshake_result;
    assign hs_mode = line_status.hs_active & sys_reg.high_speed_enable;
    assign bus_reset = line_status.bus_reset;
    assign pad_ctrl = pad_reg;
    assign irq_pin_out = irq_out_reg;
    assign pwr_mode = mode_reg;
    assign access_ready = accept;
endmodule // usp_power_ctrl

// >>> test/usp_power_chk.sv
`timescale 1ns/10ps
module usp_power_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sys_wr,
    input wire usp_pkg::usp_sys_cfg_type sys_wdata,
    input wire logic cpu_wr,
    input wire logic [6:0] cpu_addr,
    input wire logic vbus_in,
    input wire usp_pkg::usp_sys_cfg_type system_config_reg,
    input wire usp_pkg::usp_pin_cfg_type pin_config_reg,
    input wire usp_pkg::usp_irq_cfg_type irq_config_reg,
    input wire usp_pkg::usp_irq_flag_type irq_status_reg_0,
    input wire logic [1:0] handshake_result,
    input wire logic hs_mode,
    input wire logic bus_reset,
    input wire usp_pkg::usp_pad_ctrl_type pad_ctrl,
    input wire logic irq_pin_out,
    input wire logic [1:0] pwr_mode,
    input wire logic access_ready
);
    import usp_pkg::*;
    logic [1:0] up_reg;
    logic [1:0] up_next;
    logic wr_ok;
    // internal reset is still held for two edges after release
    assign up_next = {up_reg[0], 1'b1};
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            up_reg <= 2'h0;
        else
            up_reg <= up_next;
    end
    assign wr_ok = up_reg[1] && access_ready && sys_wr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_reset_held: assert property ($rose(rst_b) |-> system_config_reg == '0
        && pin_config_reg == '0 ##1 system_config_reg == '0) else $error("config not held");
    a_sleep_entry: assert property (wr_ok && sys_wdata.sleep_control |=>
        system_config_reg.sleep_control && system_config_reg[8:5] == 4'h0 && !access_ready
        && !pin_config_reg.byte_order_sel && !irq_config_reg.irq_output_sense)
        else $error("sleep entry wrong");
    a_normal_state: assert property (pwr_mode == MODE_NORMAL |->
        system_config_reg[8:7] == 2'h3 && system_config_reg[5] && !system_config_reg[1]
        && system_config_reg[0]) else $error("normal mode bits wrong");
    a_sleep_state: assert property (pwr_mode == MODE_SLEEP |->
        system_config_reg[8:5] == 4'h0 && system_config_reg[1:0] == 2'h3)
        else $error("sleep mode bits wrong");
    a_clock_stop: assert property (pwr_mode == MODE_CLOCK_STOP |->
        system_config_reg[8:5] == 4'h0 && system_config_reg[4] && system_config_reg[1:0] == 2'h1)
        else $error("stop mode bits wrong");
    a_wake_access: assert property (up_reg[1] && cpu_wr && cpu_addr == WAKE_ACCESS_ADDR
        && system_config_reg.sleep_control && !irq_config_reg.wake_on_access_ctrl |=>
        !system_config_reg.sleep_control && system_config_reg.osc_buffer_enable)
        else $error("access did not wake");
    a_hs_off: assert property (!system_config_reg.high_speed_enable |-> !hs_mode)
        else $error("high speed while disabled");
    a_pullup_off: assert property (!system_config_reg.dplus_pullup_enable [*2] |->
        !pad_ctrl.pullup_on && !pad_ctrl.hs_term_on) else $error("pull-up still on");
    a_vbus_flag: assert property (up_reg[1] && $changed(vbus_in)
        && pwr_mode == MODE_SLEEP && irq_config_reg.vbus_change_irq_enable |->
        ##[2:8] irq_status_reg_0.vbus_change_flag
        && irq_pin_out == irq_config_reg.irq_output_sense) else $error("vbus change lost");
    a_hsk_start: assert property (bus_reset |-> ##[0:1] handshake_result ==
        (system_config_reg.high_speed_enable ? HSK_IN_PROGRESS : HSK_FULL_SPEED))
        else $error("handshake start wrong");
endmodule // usp_power_chk
bind usp_power_ctrl usp_power_chk chk (.core_clk, .rst_b, .sys_wr, .sys_wdata, .cpu_wr, .cpu_addr,
    .vbus_in, .system_config_reg, .pin_config_reg, .irq_config_reg, .irq_status_reg_0,
    .handshake_result, .hs_mode, .bus_reset, .pad_ctrl, .irq_pin_out, .pwr_mode, .access_ready);

// >>> test/usp_host_model.sv
`timescale 1ns/10ps
module usp_host_model (
    input wire logic core_clk,
    input wire logic [1:0] line_cmd,
    input wire logic chirp_cmd,
    input wire logic vbus_cmd,
    output logic dplus_in,
    output logic dminus_in,
    output logic vbus_in,
    output logic host_chirp
);
    import usp_pkg::*;
    int se0_cnt = 0;
    initial
    begin
        dplus_in = 1'b1;
        dminus_in = 1'b0;
        vbus_in = 1'b0;
        host_chirp = 1'b0;
    end
    always @(posedge core_clk)
    begin
        #7;
        dplus_in = line_cmd[1];
        dminus_in = line_cmd[0];
        vbus_in = vbus_cmd;
        se0_cnt = (line_cmd == LINE_SE0) ? se0_cnt + 1 : 0;
    end
    always @(posedge core_clk)
        host_chirp <= chirp_cmd && se0_cnt > 100;
endmodule // usp_host_model

// >>> test/usb_ctrl_system_power_control_test.sv
`timescale 1ns/10ps
module usb_ctrl_system_power_control_test;
    import usp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sys_wr = 1'b0;
    logic pin_wr = 1'b0;
    logic irq_wr = 1'b0;
    logic cpu_wr = 1'b0;
    logic chirp_cmd = 1'b0;
    logic vbus_cmd = 1'b0;
    logic rst_seen = 1'b0;
    logic [DMA_CHANNELS-1:0] dma_wr = '0;
    logic [6:0] cpu_addr = 7'h00;
    logic [1:0] line_cmd = LINE_J;
    usp_sys_cfg_type sys_wdata = '0;
    usp_pin_cfg_type pin_wdata = '0;
    usp_dma_cfg_type dma_wdata = '0;
    usp_irq_cfg_type irq_wdata = '0;
    usp_irq_flag_type irq_clr = '0;
    logic dplus_in, dminus_in, vbus_in, host_chirp, hs_mode, bus_reset, irq_pin_out, access_ready;
    logic [1:0] handshake_result, pwr_mode;
    usp_sys_cfg_type system_config_reg, exp_sys;
    usp_pin_cfg_type pin_config_reg, exp_pin;
    usp_dma_cfg_type [DMA_CHANNELS-1:0] dma_channel_config_reg, exp_dma;
    usp_irq_cfg_type irq_config_reg, exp_irq;
    usp_irq_flag_type irq_status_reg_0;
    usp_pad_ctrl_type pad_ctrl;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    always #20 core_clk = ~core_clk;
    usp_power_ctrl #(.SUSPEND_CYCLES(20), .WAKE_CYCLES(10)) dut (.core_clk, .rst_b, .sys_wr,
        .sys_wdata, .pin_wr, .pin_wdata, .dma_wr, .dma_wdata, .irq_wr, .irq_wdata, .irq_clr,
        .cpu_wr, .cpu_addr, .dplus_in, .dminus_in, .vbus_in, .host_chirp, .system_config_reg,
        .pin_config_reg, .dma_channel_config_reg, .irq_config_reg, .irq_status_reg_0,
        .handshake_result, .hs_mode, .bus_reset, .pad_ctrl, .irq_pin_out, .pwr_mode, .access_ready);
    usp_host_model host (.core_clk, .line_cmd, .chirp_cmd, .vbus_cmd, .dplus_in, .dminus_in,
        .vbus_in, .host_chirp);
    task automatic test_done();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (bus_reset === 1'b1)
            rst_seen = 1'b1;
        if (cycles == 4000)
        begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_all();
        chk(system_config_reg, exp_sys);
        chk(pin_config_reg, exp_pin);
        chk(dma_channel_config_reg, exp_dma);
        chk(irq_config_reg, exp_irq);
    endtask
    task automatic wr_sys(input usp_sys_cfg_type d);
        if (access_ready === 1'b1)
        begin
            d.osc_buffer_enable = d.osc_buffer_enable | exp_sys.osc_buffer_enable;
            exp_sys = d;
            if (d.sleep_control)
            begin
                exp_sys[8:5] = 4'h0;
                exp_pin.byte_order_sel = 1'b0;
                exp_dma[0][2:0] = 3'h0;
                exp_dma[1][2:0] = 3'h0;
                exp_irq[1:0] = 2'h0;
            end
        end
        @(posedge core_clk);
        sys_wr <= 1'b1;
        sys_wdata <= d;
        @(posedge core_clk);
        sys_wr <= 1'b0;
        #1;
        chk(system_config_reg, exp_sys);
    endtask
    task automatic wr_cfg(input usp_pin_cfg_type p, input usp_dma_cfg_type d0, d1,
        input usp_irq_cfg_type q);
        @(posedge core_clk);
        pin_wr <= 1'b1;
        pin_wdata <= p;
        irq_wr <= 1'b1;
        irq_wdata <= q;
        dma_wr <= 2'b01;
        dma_wdata <= d0;
        @(posedge core_clk);
        pin_wr <= 1'b0;
        irq_wr <= 1'b0;
        dma_wr <= 2'b10;
        dma_wdata <= d1;
        @(posedge core_clk);
        dma_wr <= 2'b00;
        #1;
        exp_pin = p;
        exp_dma = {d1, d0};
        exp_irq = q;
        check_all();
    endtask
    task automatic clr_flags();
        @(posedge core_clk);
        irq_clr <= 2'b11;
        @(posedge core_clk);
        irq_clr <= 2'b00;
        #1;
        chk(irq_status_reg_0, 2'b00);
    endtask
    task automatic usb_reset(input logic chirp, input logic [1:0] exp_hsk);
        rst_seen = 1'b0;
        @(posedge core_clk);
        line_cmd <= LINE_SE0;
        chirp_cmd <= chirp;
        repeat (160) @(posedge core_clk);
        line_cmd <= LINE_J;
        chirp_cmd <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        chk(rst_seen, 1'b1);
        chk(handshake_result, exp_hsk);
        chk(hs_mode, exp_hsk == HSK_HIGH_SPEED);
        chk(pad_ctrl, 3'b101 ^ {3{exp_hsk == HSK_HIGH_SPEED}});
        repeat (30) @(posedge core_clk);
        #1;
        chk(pad_ctrl, 3'b101);
    endtask
    task automatic sleep_wake(input int how);
        usp_sys_cfg_type s;
        logic [1:0] fx;
        fx = (how == 0) ? 2'b10 : (how == 2) ? 2'b01 : 2'b00;
        clr_flags();
        s = exp_sys;
        s.internal_clock_enable = 1'b0;
        wr_sys(s);
        s.pll_enable = 1'b0;
        wr_sys(s);
        s.ref_clock_enable = 1'b0;
        wr_sys(s);
        s.sleep_control = 1'b1;
        wr_sys(s);
        check_all();
        chk(pwr_mode, MODE_SLEEP);
        wr_sys(~s);
        @(posedge core_clk);
        if (how == 0)
            vbus_cmd <= ~vbus_cmd;
        cpu_wr <= (how == 1);
        cpu_addr <= WAKE_ACCESS_ADDR;
        line_cmd <= (how == 2) ? 2'h1 : LINE_J;
        @(posedge core_clk);
        cpu_wr <= 1'b0;
        repeat (3) @(posedge core_clk);
        line_cmd <= LINE_J;
        for (int n = 0; n < 200 && access_ready !== 1'b1; n++)
            @(posedge core_clk);
        #1;
        exp_sys.sleep_control = 1'b0;
        exp_sys.osc_buffer_enable = 1'b1;
        exp_sys[7:5] = {3{exp_sys.auto_clock_supply_mode}};
        check_all();
        chk(irq_status_reg_0, fx);
        chk(irq_pin_out, fx == 2'b00);
        wr_cfg(2'($urandom), 4'($urandom), 4'($urandom), {2'b11, 2'($urandom)});
    endtask
    initial
    begin
        usp_sys_cfg_type s;
        void'($urandom(1935));
        exp_sys = '0;
        exp_pin = '0;
        exp_dma = '0;
        exp_irq = '0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        sys_wr <= 1'b1;
        sys_wdata <= '1;
        @(posedge core_clk);
        sys_wr <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check_all();
        chk(pwr_mode, MODE_OTHER);
        s = '0;
        s.auto_clock_supply_mode = 1'b1;
        s.controller_enable = 1'b1;
        wr_sys(s);
        chk(pwr_mode, MODE_CLOCK_STOP);
        s.crystal_freq_sel = 2'($urandom);
        s.osc_buffer_enable = 1'b1;
        wr_sys(s);
        s[7:6] = 2'h3;
        s.high_speed_enable = 1'b1;
        s.dplus_pullup_enable = 1'b1;
        wr_sys(s);
        s.internal_clock_enable = 1'b1;
        wr_sys(s);
        chk(pwr_mode, MODE_NORMAL);
        wr_cfg(2'($urandom), 4'($urandom), 4'($urandom), {2'b11, 2'($urandom)});
        usb_reset(1'b1, HSK_HIGH_SPEED);
        s.internal_clock_enable = 1'b0;
        wr_sys(s);
        s.high_speed_enable = 1'b0;
        wr_sys(s);
        s.internal_clock_enable = 1'b1;
        wr_sys(s);
        usb_reset(1'b1, HSK_FULL_SPEED);
        s.dplus_pullup_enable = 1'b0;
        wr_sys(s);
        repeat (2) @(posedge core_clk);
        #1;
        chk(pad_ctrl[2:1], 2'b00);
        s.dplus_pullup_enable = 1'b1;
        wr_sys(s);
        for (int k = 0; k < 3; k++)
            sleep_wake(k);
        s = exp_sys;
        s.controller_enable = 1'b0;
        wr_sys(s);
        repeat (2) @(posedge core_clk);
        #1;
        chk(handshake_result, HSK_UNDECIDED);
        test_done();
    end
endmodule // usb_ctrl_system_power_control_test
